// ---- core/abs_pkg.sv ----
// constants, types and register map of the auto-buffered three-wire serial block
// assumes an APB master with 32-bit data and 8-bit byte addresses
package abs_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIVSEL = 8'h08;
  localparam logic [7:0] OFS_ENDPT = 8'h0C;
  localparam logic [7:0] OFS_GAP = 8'h10;
  localparam logic [7:0] OFS_TRIG = 8'h14;
  localparam logic [7:0] OFS_ADDRCNT = 8'h18;
  localparam logic [7:0] OFS_DONE = 8'h1C;
  // buffer words live where address bit 7 is set
  localparam int unsigned RAM_SEL_BIT = 7;
  // ==========================================================
  // field positions
  localparam int unsigned TRIG_START_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_SRC_LSB = 1;
  localparam int unsigned DONE_FLAG_BIT = 0;
  // ==========================================================
  // reset values and sizes
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [7:0] DIVSEL_RST = 8'h00;
  localparam logic [7:0] GAP_RST = 8'h00;
  localparam int unsigned BUF_BYTES = 32;
  localparam logic [4:0] LAST_PHASE = 5'h0F;
  // ==========================================================
  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic serial_unit_enable;
    logic auto_mode_select;
    logic repeat_mode_bit;
    logic master_select;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic [1:0] rsvd;
  } abs_mode_t;
  // engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_SHIFT = 5'h04,
    ST_STORE = 5'h08,
    ST_GAP = 5'h10
  } abs_state_t;
endpackage : abs_pkg

// ---- core/abs_div.sv ----
// serial clock divider: a one-cycle tick every limit+1 clocks
// assumes clear is held whenever no master shifting is under way
`timescale 1ns/10ps
module abs_div #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic [CNT_W-1:0] limit,
  // rate enable
  output logic tick
);
  // ==========================================================
  // elaboration check
  if (CNT_W < 2) begin : g_chk
    $error("divider width too small");
  end
  logic [CNT_W-1:0] cnt; // running count
  logic [CNT_W-1:0] next_cnt;
  // terminal count gives the tick
  assign tick = !clear && (cnt >= limit);
  // next count: cleared or wrapping
  always_comb begin
    if (clear || tick) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end
  // count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : abs_div

// ---- core/abs_serial.sv ----
// auto-buffered three-wire serial unit with APB registers and buffer
// assumes link inputs synchronous to pclk; pins muxed outside by the func flags
`timescale 1ns/10ps
module abs_serial
  import abs_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = BUF_BYTES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // serial data pins
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic sdo_oe,
  // pin ownership, high while the serial unit owns the pin
  output logic sck_func,
  output logic sdi_func,
  output logic sdo_func,
  // completion request
  output logic transfer_done_irq
);
  localparam int unsigned AW = $clog2(BUF_DEPTH);
  // ==========================================================
  // elaboration check: power of two, fits the address window
  if ((BUF_DEPTH < 2) || (BUF_DEPTH > BUF_BYTES) || ((BUF_DEPTH & (BUF_DEPTH - 1)) != 0)) begin : g_chk
    $error("buffer depth unsupported");
  end
  // ==========================================================
  // state declarations
  abs_mode_t serial_mode_reg, next_mode; // mode bits
  logic [1:0] clk_src, next_clk_src; // clock source select
  logic [7:0] clock_divider_select, next_div; // division ratio
  logic [AW-1:0] transfer_end_point, next_end_pt; // last address
  logic [7:0] inter_byte_interval, next_gap; // idle length
  logic transfer_done_flag, next_done_flag; // sticky done
  logic [31:0] next_prdata; // read word
  abs_state_t state, next_state; // engine state
  logic [AW-1:0] transfer_address_counter, next_cnt;
  logic transfer_busy_flag, next_busy;
  logic [7:0] serial_shift_reg, next_sh;
  logic sdo_q, next_sdo_q; // data out latch
  logic sck_q, next_sck_q; // master clock level
  logic sck_prev; // last sampled external clock
  logic [4:0] phase, next_phase; // half-bit position
  logic [7:0] gap_cnt, next_gap_cnt; // interval count
  logic next_irq;
  logic [7:0] buf_mem [BUF_DEPTH]; // transfer buffer
  // ==========================================================
  // bus decode
  logic acc, wr, ram_hit, reg_hit, bad, cpu_ram, cpu_ram_wr, start;
  logic [AW-1:0] ram_idx;
  logic [31:0] rd_word;
  logic master, fall_ev, rise_ev, tick, gap_done, eng_we;
  logic [15:0] div_base, div_lim;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign ram_idx = paddr[2+:AW];
  assign ram_hit = paddr[RAM_SEL_BIT] && (paddr[1:0] == 2'h0) && (int'(paddr[6:2]) < BUF_DEPTH);
  assign reg_hit = (paddr == OFS_MODE) || (paddr == OFS_STATUS) || (paddr == OFS_DIVSEL)
    || (paddr == OFS_ENDPT) || (paddr == OFS_GAP) || (paddr == OFS_TRIG)
    || (paddr == OFS_ADDRCNT) || (paddr == OFS_DONE);
  // buffer refused while unit disabled
  assign bad = !(reg_hit || (ram_hit && serial_mode_reg.serial_unit_enable));
  assign pready = 1'b1;
  assign pslverr = acc && bad;
  // processor holds the buffer this cycle; engine waits on it
  assign cpu_ram = psel && ram_hit && serial_mode_reg.serial_unit_enable;
  assign cpu_ram_wr = wr && ram_hit && serial_mode_reg.serial_unit_enable;
  // trigger accepted only when enabled, automatic and idle
  assign start = wr && (paddr == OFS_TRIG) && pwdata[TRIG_START_BIT] && serial_mode_reg.serial_unit_enable
    && serial_mode_reg.auto_mode_select && !transfer_busy_flag;
  // ==========================================================
  // read mux, captured in the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ram_hit) begin
      if (serial_mode_reg.serial_unit_enable) begin
        rd_word[7:0] = buf_mem[ram_idx];
      end
    end else begin
      case (paddr)
        OFS_MODE: rd_word[7:0] = serial_mode_reg;
        OFS_STATUS: begin
          rd_word[STATUS_BUSY_BIT] = transfer_busy_flag;
          rd_word[STATUS_SRC_LSB+:2] = clk_src;
        end
        OFS_DIVSEL: rd_word[7:0] = clock_divider_select;
        OFS_ENDPT: rd_word[AW-1:0] = transfer_end_point;
        OFS_GAP: rd_word[7:0] = inter_byte_interval;
        OFS_ADDRCNT: rd_word[AW-1:0] = transfer_address_counter;
        OFS_DONE: rd_word[DONE_FLAG_BIT] = transfer_done_flag;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // register group: next values
  always_comb begin
    next_mode = serial_mode_reg;
    next_clk_src = clk_src;
    next_div = clock_divider_select;
    next_end_pt = transfer_end_point;
    next_gap = inter_byte_interval;
    next_done_flag = transfer_done_flag;
    next_prdata = prdata;
    // read data sampled in setup
    if (psel && !penable && !pwrite) begin
      next_prdata = rd_word;
    end
    if (wr && !bad) begin
      case (paddr)
        OFS_MODE: next_mode = abs_mode_t'({pwdata[7:2], 2'h0});
        OFS_STATUS: next_clk_src = pwdata[STATUS_SRC_LSB+:2];
        OFS_DIVSEL: next_div = pwdata[7:0];
        OFS_ENDPT: next_end_pt = pwdata[AW-1:0];
        OFS_GAP: next_gap = pwdata[7:0];
        OFS_DONE: begin
          // write one to clear
          if (pwdata[DONE_FLAG_BIT]) begin
            next_done_flag = 1'b0;
          end
        end
        default: next_done_flag = next_done_flag;
      endcase
    end
    // set wins over clear
    if (next_irq) begin
      next_done_flag = 1'b1;
    end
  end
  // register group: storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_reg <= abs_mode_t'(MODE_RST);
      clk_src <= SRC_RST;
      clock_divider_select <= DIVSEL_RST;
      transfer_end_point <= '0;
      inter_byte_interval <= GAP_RST;
      transfer_done_flag <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      serial_mode_reg <= next_mode;
      clk_src <= next_clk_src;
      clock_divider_select <= next_div;
      transfer_end_point <= next_end_pt;
      inter_byte_interval <= next_gap;
      transfer_done_flag <= next_done_flag;
      prdata <= next_prdata;
    end
  end
  // ==========================================================
  // rate: source picks a power-of-two prescale, select the ratio
  assign div_base = {8'h00, clock_divider_select} + 16'h0001;
  assign div_lim = (div_base << clk_src) - 16'h0001;
  assign master = serial_mode_reg.master_select;
  abs_div #(
    .CNT_W(16)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!serial_mode_reg.serial_unit_enable || !master || (state != ST_SHIFT)),
    .limit(div_lim),
    .tick(tick)
  );
  // slave edges come from the partner's clock only
  assign fall_ev = master ? (tick && !phase[0]) : (sck_prev && !sck_i && !phase[0]);
  assign rise_ev = master ? (tick && phase[0]) : (!sck_prev && sck_i && phase[0]);
  assign gap_done = (gap_cnt >= inter_byte_interval);
  assign eng_we = (state == ST_STORE) && !cpu_ram && serial_mode_reg.rx_enable_bit;
  // ==========================================================
  // engine group: next values
  always_comb begin
    next_state = state;
    next_cnt = transfer_address_counter;
    next_busy = transfer_busy_flag;
    next_sh = serial_shift_reg;
    next_sdo_q = sdo_q;
    next_sck_q = sck_q;
    next_phase = phase;
    next_gap_cnt = gap_cnt;
    next_irq = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_busy = 1'b1;
          next_cnt = '0;
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // wait while the processor holds the buffer
        if (!cpu_ram) begin
          next_sh = buf_mem[transfer_address_counter];
          next_sdo_q = next_sh[7];
          next_phase = 5'h00;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (fall_ev) begin
          // falling edge: present the next bit
          next_sck_q = 1'b0;
          next_sdo_q = serial_shift_reg[7];
          next_phase = phase + 5'h01;
        end else if (rise_ev) begin
          // rising edge: sample the input
          next_sck_q = 1'b1;
          next_sh = {serial_shift_reg[6:0], serial_data_in && serial_mode_reg.rx_enable_bit};
          next_phase = phase + 5'h01;
          if (phase == LAST_PHASE) begin
            next_state = ST_STORE;
          end
        end
      end
      ST_STORE: begin
        // received byte goes back at the same address
        if (!cpu_ram) begin
          next_gap_cnt = 8'h00;
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!gap_done) begin
          next_gap_cnt = gap_cnt + 8'h01;
        end else if (transfer_address_counter == transfer_end_point) begin
          if (serial_mode_reg.repeat_mode_bit) begin
            next_cnt = '0;
            next_state = ST_LOAD;
          end else begin
            next_busy = 1'b0;
            next_irq = 1'b1;
            next_state = ST_IDLE;
          end
        end else begin
          next_cnt = transfer_address_counter + 1'b1;
          next_state = ST_LOAD;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // disabled: state, busy, address counter and phase cleared, clock parked high
    if (!serial_mode_reg.serial_unit_enable) begin
      next_state = ST_IDLE;
      next_busy = 1'b0;
      next_cnt = '0;
      next_phase = 5'h00;
      next_sck_q = 1'b1;
      next_irq = 1'b0;
    end
  end
  // engine group: storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      transfer_address_counter <= '0;
      transfer_busy_flag <= 1'b0;
      serial_shift_reg <= 8'h00;
      sdo_q <= 1'b1;
      sck_q <= 1'b1;
      sck_prev <= 1'b1;
      phase <= 5'h00;
      gap_cnt <= 8'h00;
      transfer_done_irq <= 1'b0;
    end else begin
      state <= next_state;
      transfer_address_counter <= next_cnt;
      transfer_busy_flag <= next_busy;
      serial_shift_reg <= next_sh;
      sdo_q <= next_sdo_q;
      sck_q <= next_sck_q;
      sck_prev <= sck_i;
      phase <= next_phase;
      gap_cnt <= next_gap_cnt;
      transfer_done_irq <= next_irq;
    end
  end
  // ==========================================================
  // buffer storage: processor first, engine when free
  always_ff @(posedge pclk) begin
    if (cpu_ram_wr) begin
      buf_mem[ram_idx] <= pwdata[7:0];
    end else if (eng_we) begin
      buf_mem[transfer_address_counter] <= serial_shift_reg;
    end
  end
  // ==========================================================
  // pins
  assign sck_o = sck_q;
  assign sck_oe = serial_mode_reg.serial_unit_enable && master;
  assign serial_data_out = sdo_q;
  assign sdo_oe = serial_mode_reg.serial_unit_enable && serial_mode_reg.tx_enable_bit;
  assign sck_func = serial_mode_reg.serial_unit_enable;
  assign sdi_func = serial_mode_reg.serial_unit_enable && serial_mode_reg.rx_enable_bit;
  assign sdo_func = sdo_oe;
  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_off_parks:
  assert property (!serial_mode_reg.serial_unit_enable |-> (!sck_oe && !sdo_oe && !sdi_func && !sck_func)
    ##1 (state == ST_IDLE && transfer_address_counter == '0 && !transfer_busy_flag))
    else $error("disabled unit not parked");
  a_ram_locked:
  assert property (acc && ram_hit && !serial_mode_reg.serial_unit_enable
    |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("buffer reachable while disabled");
  a_clk_dir:
  assert property (serial_mode_reg.serial_unit_enable |-> sck_oe == serial_mode_reg.master_select)
    else $error("clock pin direction wrong");
  a_tx_release:
  assert property (!serial_mode_reg.tx_enable_bit |-> !sdo_oe && !sdo_func)
    else $error("data out pin not released");
  a_start_busy:
  assert property (start |=> transfer_busy_flag && state == ST_LOAD && transfer_address_counter == '0)
    else $error("trigger not accepted");
  a_load_copy:
  assert property (state == ST_LOAD && !cpu_ram && serial_mode_reg.serial_unit_enable
    |=> serial_shift_reg == buf_mem[$past(transfer_address_counter)])
    else $error("shifter not loaded from buffer");
  a_rx_store:
  assert property (eng_we && !cpu_ram_wr |=> buf_mem[$past(transfer_address_counter)] == $past(serial_shift_reg))
    else $error("received byte not stored");
  a_end_done:
  assert property (state == ST_GAP && gap_done && transfer_address_counter == transfer_end_point
    && !serial_mode_reg.repeat_mode_bit && serial_mode_reg.serial_unit_enable
    |=> transfer_done_irq && !transfer_busy_flag ##1 !transfer_done_irq)
    else $error("termination not signalled");
  a_repeat_wrap:
  assert property (state == ST_GAP && gap_done && transfer_address_counter == transfer_end_point
    && serial_mode_reg.repeat_mode_bit && serial_mode_reg.serial_unit_enable
    |=> state == ST_LOAD && transfer_address_counter == '0 && transfer_busy_flag)
    else $error("repeat did not restart");
  a_gap_hold:
  assert property (state == ST_GAP && !gap_done && serial_mode_reg.serial_unit_enable |=> state == ST_GAP)
    else $error("interval cut short");
  a_collide_wait:
  assert property (state == ST_LOAD && cpu_ram && serial_mode_reg.serial_unit_enable |=> state == ST_LOAD)
    else $error("engine ignored buffer collision");
  a_slave_still:
  assert property (state == ST_SHIFT && !master && sck_i == sck_prev |=> phase == $past(phase))
    else $error("slave shifted without clock edge");
  c_start: cover property (start);
  c_done: cover property (transfer_done_irq);
  c_repeat: cover property (state == ST_GAP && gap_done && serial_mode_reg.repeat_mode_bit ##1 state == ST_LOAD);
  c_collide: cover property (state == ST_LOAD && cpu_ram);
endmodule : abs_serial

// ---- testbench/abs_link_model.sv ----
// serial partner on the three-wire link: samples on rising clock, drives on falling clock
// assumes link clock and unit data are synchronous to pclk
`timescale 1ns/10ps
module abs_link_model #(
  parameter int HALF = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic sck_drv,
  // bench control
  input wire logic [7:0] reply,
  input wire logic clk_go,
  // received byte report
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  logic sck_q; // previous clock level
  logic [7:0] sh; // incoming bits
  logic [7:0] tx; // outgoing bits
  int nb; // rising edges in this byte
  // ==========================================================
  // shifter: msb first, data out after falling edge, sample on rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
      nb <= 0;
      rx_stb <= 1'b0;
      sdi <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      sck_q <= sck;
      if (sck_q && !sck) begin
        sdi <= (nb == 0) ? reply[7] : tx[7];
        tx <= (nb == 0) ? {reply[6:0], 1'b0} : {tx[6:0], 1'b0};
      end else if (!sck_q && sck) begin
        sh <= {sh[6:0], sdo};
        nb <= (nb == 7) ? 0 : nb + 1;
        if (nb == 7) begin
          rx_byte <= {sh[6:0], sdo};
          rx_stb <= 1'b1;
          sdi <= ~sdi; // hold time over: line no longer shows the last bit
        end
      end
    end
  end
  // ==========================================================
  // slave-mode clock: eight periods per request, still high otherwise
  initial begin
    sck_drv = 1'b1;
    forever begin
      @(posedge pclk);
      if (clk_go) begin
        repeat (8) begin
          repeat (HALF) @(posedge pclk);
          sck_drv <= 1'b0;
          repeat (HALF) @(posedge pclk);
          sck_drv <= 1'b1;
        end
      end
    end
  end
endmodule : abs_link_model

// ---- testbench/abs_serial_tb.sv ----
// self-checking bench of the auto-buffered serial unit over apb
// assumes the link partner model and a zero-wait apb slave
`timescale 1ns/10ps
module abs_serial_tb
  import abs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, reply, b[4];
  logic [31:0] pwdata, prdata;
  logic sck_o, sck_oe, sck_drv, sck, sdi, sdo, sdo_oe, sck_func, sdi_func, sdo_func, irq, clk_go, rx_stb;
  logic [7:0] rx_byte;
  logic [33:0] aq[$], n; // {write, error, data} notes
  logic [7:0] sq[$]; // bytes the partner should see
  int failures, samples_checked, irqs, nrx, lowc, lastlow, seed, rd_n;
  assign sck = sck_oe ? sck_o : sck_drv;
  abs_serial DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck),
    .sck_o(sck_o), .sck_oe(sck_oe), .serial_data_in(sdi), .serial_data_out(sdo), .sdo_oe(sdo_oe),
    .sck_func(sck_func), .sdi_func(sdi_func), .sdo_func(sdo_func), .transfer_done_irq(irq));
  abs_link_model PEER (.pclk(pclk), .presetn(presetn), .sck(sck), .sdo(sdo_oe ? sdo : 1'b1), .sdi(sdi),
    .sck_drv(sck_drv), .reply(reply), .clk_go(clk_go), .rx_byte(rx_byte), .rx_stb(rx_stb));
  // ==========================================================
  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task test_done();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // bounded wait on a bench counter
  task automatic waitc(ref int c, input int lim, input string nm);
    int k;
    k = 0;
    while (c < lim && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (c < lim) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", nm, lim, c);
      test_done();
    end
  endtask : waitc
  // one apb transfer, result noted for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    aq.push_back({w, e, d});
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // a slave that never answers ends the run
    if (pready !== 1'b1) begin
      failures++;
      $display("[ERR] pready expected 1 seen %b", pready);
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ==========================================================
  // monitors: apb answers, partner bytes, done pulses, clock low time
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      n = aq.pop_front();
      chk("pslverr", 32'(n[32]), 32'(pslverr));
      if (!n[33] && !n[32]) chk("prdata", n[31:0], prdata);
    end
    if (rx_stb) nrx++;
    if (rx_stb && sq.size() > 0) chk("link byte", 32'(sq.pop_front()), 32'(rx_byte));
    if (irq === 1'b1) irqs++;
    if (sck_oe && !sck_o) lowc++;
    else if (lowc > 0) begin
      lastlow = lowc;
      lowc = 0;
    end
  end
  // pin ownership and enables, looked at once the register edge has settled
  task pin_chk(input logic [31:0] e);
    @(negedge pclk);
    chk("pins", e, 32'({sck_func, sdi_func, sdo_func, sck_oe, sdo_oe}));
  endtask : pin_chk
  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, clk_go, reply, presetn} = '0;
    seed = 15;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_MODE, 32'(MODE_RST), 0);
    apb(0, OFS_DIVSEL, 32'(DIVSEL_RST), 0);
    apb(0, OFS_GAP, 32'(GAP_RST), 0);
    pin_chk(32'h0);
    apb(1, 8'h80, 32'h55, 1);
    apb(0, 8'h80, 0, 1);
    apb(0, 8'h20, 0, 1);
    apb(1, OFS_TRIG, 32'h1, 0);
    apb(0, OFS_STATUS, 32'h0, 0);
    // master block of four bytes
    apb(1, OFS_MODE, 32'hDF, 0);
    apb(0, OFS_MODE, 32'hDC, 0);
    pin_chk(32'h1F);
    apb(1, OFS_STATUS, 32'h2, 0);
    apb(1, OFS_DIVSEL, 32'h3, 0);
    apb(1, OFS_ENDPT, 32'h3, 0);
    apb(1, OFS_GAP, 32'h40, 0);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($random(seed));
      apb(1, 8'(8'h80 + 4 * i), 32'(b[i]), 0);
      sq.push_back(b[i]);
    end
    reply = 8'($random(seed));
    apb(1, OFS_TRIG, 32'h1, 0);
    apb(0, OFS_STATUS, 32'h3, 0);
    apb(0, 8'h8C, 32'(b[3]), 0);
    waitc(irqs, 1, "done pulses");
    apb(0, OFS_STATUS, 32'h2, 0);
    apb(0, OFS_ADDRCNT, 32'h3, 0);
    apb(0, OFS_DONE, 32'h1, 0);
    apb(1, OFS_DONE, 32'h1, 0);
    apb(0, OFS_DONE, 32'h0, 0);
    for (int i = 0; i < 4; i++) apb(0, 8'(8'h80 + 4 * i), 32'(reply), 0);
    chk("clock low", 32'h8, 32'(lastlow));
    // repeat mode, transmit only, stopped by disable in the gap
    apb(1, OFS_MODE, 32'hF8, 0);
    pin_chk(32'h17);
    for (int i = 0; i < 2; i++) begin
      b[i] = 8'($random(seed));
      apb(1, 8'(8'h80 + 4 * i), 32'(b[i]), 0);
    end
    apb(1, OFS_ENDPT, 32'h1, 0);
    sq.push_back(b[0]);
    sq.push_back(b[1]);
    sq.push_back(b[0]);
    nrx = 0;
    apb(1, OFS_TRIG, 32'h1, 0);
    // keep the processor on the buffer so loads and stores collide
    rd_n = 0;
    while (nrx < 3 && rd_n < 2000) begin
      apb(0, 8'h84, 32'(b[1]), 0);
      rd_n++;
    end
    waitc(nrx, 3, "link bytes");
    apb(1, OFS_MODE, 32'h0, 0);
    apb(0, OFS_ADDRCNT, 32'h0, 0);
    apb(0, OFS_DONE, 32'h0, 0);
    pin_chk(32'h0);
    chk("done pulses", 32'h1, 32'(irqs));
    // slave receive only, clock from the partner
    apb(1, OFS_MODE, 32'hC4, 0);
    pin_chk(32'h18);
    apb(1, OFS_ENDPT, 32'h0, 0);
    reply = 8'($random(seed));
    // released data out reaches the partner as the idle level
    sq.push_back(8'hFF);
    apb(1, OFS_TRIG, 32'h1, 0);
    clk_go <= 1'b1;
    @(posedge pclk);
    clk_go <= 1'b0;
    waitc(irqs, 2, "done pulses");
    apb(0, 8'h80, 32'(reply), 0);
    apb(0, 8'h84, 32'(b[1]), 0);
    repeat (2) @(posedge pclk);
    test_done();
  end
endmodule : abs_serial_tb
